/* hdl/tph_pkg.sv */
// package for the 8-bit timer pwm block: field codes, reset values, timing counts
// assumes one 40 MHz clock; everything else is plain ports of the top module
package tph_pkg;

  // ----------------------------------------------------------------
  // count clock selection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV4 = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_DIV4096 = 3'h4;
  localparam logic [2:0] CKS_SLOW = 3'h5;

  // ----------------------------------------------------------------
  // prescaler tap positions (divide by 2^n uses bit n-1)
  // ----------------------------------------------------------------
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV16 = 3;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV4096 = 11;
  localparam int PRESC_W = 12;

  // ----------------------------------------------------------------
  // operating mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [11:0] PRESC_RESET = 12'h000;
  // count clocks needed between a duty write and its transfer
  localparam int DUTY_XFER_TICKS = 3;
  localparam logic [1:0] AGE_RESET = 2'h0;

  // phase of the comparison
  typedef enum logic {TPH_CMP_PERIOD, TPH_CMP_DUTY} tph_phase_t;

endpackage

/* hdl/tph_timer_pwm.sv */
// 8-bit timer with interval and pwm output modes, configured by plain ports
// assumes configuration ports come from logic on ref_clk_i; the slow clock tick
// arrives from another domain and is resynchronised here
//
// Notes on behaviour
// [R1] software keeps duty below period, 8-bit values
// [R2] first comparison after enable uses period
// [R3] period match: clear, interrupt, output active in pwm mode, toggled in interval mode
// [R4] duty match: output inactive, back to period
// [R5] cycle (N+1) counts, active width (M+1)
// [R6] first count clock after enable is masked
// [R7] disable forces interrupt and output inactive
// [R8] duty writes latched, moved at duty match; a stopped timer takes them straight into the compare register
// [R9] transfer needs three count clocks after write
// [R10] software rewrites duty after each restart
// [R11] disable clears counter; enable starts counting
// [R12] software leaves period alone while counting
// [R13] software leaves mode bits alone while counting
// [R14] output enable gates pin; level picks default
// [R15] interrupt is one-cycle pulse per period match
// [R16] disabled output holds default level
`timescale 1ns/1ps

module tph_timer_pwm #(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_i, // 40 MHz peripheral clock
  input wire logic nrst_i, // synchronous reset, active low
  input wire logic count_enable_bit_i, // count enable
  input wire logic count_clock_sel_hi_i, // clock select bit 2
  input wire logic count_clock_sel_mid_i, // clock select bit 1
  input wire logic count_clock_sel_lo_i, // clock select bit 0
  input wire logic op_mode_sel_hi_i, // mode select bit 1
  input wire logic op_mode_sel_lo_i, // mode select bit 0
  input wire logic default_output_level_i, // inactive level of output
  input wire logic output_drive_enable_i, // output enable
  input wire logic slow_clk_tick_i, // slow clock (other domain), divided by 128
  input wire logic [CNT_W-1:0] period_compare_reg_i, // period value n
  input wire logic [CNT_W-1:0] duty_wdata_i, // duty value written by software
  input wire logic duty_we_i, // one-cycle write strobe for duty
  output logic timer_output_pin_o, // pin level
  output logic timer_output_pin_oe_o, // high while pin is driven
  output logic match_interrupt_o, // one-cycle pulse on period match
  output logic [CNT_W-1:0] count_o, // counter value
  output logic [CNT_W-1:0] duty_compare_reg_o // active duty compare value
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (CNT_W != 8) begin : g_bad_width
    $error("tph_timer_pwm supports only an 8-bit counter");
  end

  // ----------------------------------------------------------------
  // slow clock resynchroniser and prescaler
  // ----------------------------------------------------------------
  logic [2:0] slow_sync; // three stages; only [1] and [2] are compared
  logic slow_lvl; // filtered slow clock level
  logic slow_tick; // one cycle on each filtered rising edge
  logic [tph_pkg::PRESC_W-1:0] presc; // free divider of ref clock, cleared when stopped
  logic [tph_pkg::PRESC_W-1:0] next_presc;
  logic [2:0] next_slow_sync;
  logic next_slow_lvl;
  logic [6:0] slow_div; // divides slow clock edges by 128
  logic [6:0] next_slow_div;
  logic [2:0] cks; // selected count clock code
  logic cnt_tick; // one ref cycle per count clock

  assign cks = {count_clock_sel_hi_i, count_clock_sel_mid_i, count_clock_sel_lo_i};

  // tap strobe: all bits at and below the tap are ones
  function automatic logic tap_hit(input logic [tph_pkg::PRESC_W-1:0] p, input int tap);
    logic r;
    r = 1'b1;
    for (int i = 0; i < tph_pkg::PRESC_W; i++) begin
      if (i <= tap && !p[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  // next values of the clock source chain
  always_comb begin
    next_slow_sync = {slow_sync[1:0], slow_clk_tick_i};
    // change counts only once the second and third stage agree
    next_slow_lvl = (slow_sync[1] == slow_sync[2]) ? slow_sync[2] : slow_lvl;
    slow_tick = next_slow_lvl & ~slow_lvl;
    next_presc = count_enable_bit_i ? presc + 1'b1 : tph_pkg::PRESC_RESET;
    next_slow_div = !count_enable_bit_i ? 7'h00 : (slow_tick ? slow_div + 1'b1 : slow_div);
    unique case (cks)
      tph_pkg::CKS_DIV1: cnt_tick = 1'b1;
      tph_pkg::CKS_DIV4: cnt_tick = tap_hit(presc, tph_pkg::TAP_DIV4);
      tph_pkg::CKS_DIV16: cnt_tick = tap_hit(presc, tph_pkg::TAP_DIV16);
      tph_pkg::CKS_DIV64: cnt_tick = tap_hit(presc, tph_pkg::TAP_DIV64);
      tph_pkg::CKS_DIV4096: cnt_tick = tap_hit(presc, tph_pkg::TAP_DIV4096);
      tph_pkg::CKS_SLOW: cnt_tick = slow_tick && (slow_div == 7'h7f);
      // prohibited codes never tick
      default: cnt_tick = 1'b0;
    endcase
  end

  // registers of the clock source chain
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      slow_sync <= 3'h0;
      slow_lvl <= 1'b0;
      presc <= tph_pkg::PRESC_RESET;
      slow_div <= 7'h00;
    end else begin
      slow_sync <= next_slow_sync;
      slow_lvl <= next_slow_lvl;
      presc <= next_presc;
      slow_div <= next_slow_div;
    end
  end

  // ----------------------------------------------------------------
  // counter, compare phase, output and duty buffer
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt, next_cnt; // the 8-bit up counter
  tph_pkg::tph_phase_t phase, next_phase; // which register is compared
  logic started, next_started; // first count clock after enable swallowed
  logic out_act, next_out_act; // pwm state: 1 while in the active part
  logic irq, next_irq;
  logic [CNT_W-1:0] duty, next_duty; // active duty compare value
  logic [CNT_W-1:0] duty_hold, next_duty_hold; // latched pending duty value
  logic pend, next_pend; // a latched value waits for transfer
  logic [1:0] age, next_age; // count clocks seen since the write, saturating
  logic next_pin, next_oe;
  logic pwm_mode;
  logic cmp_period, cmp_duty;

  assign pwm_mode = ({op_mode_sel_hi_i, op_mode_sel_lo_i} == tph_pkg::MODE_PWM);
  // interval mode never looks at the duty register
  assign cmp_period = (phase == tph_pkg::TPH_CMP_PERIOD) || !pwm_mode;
  assign cmp_duty = !cmp_period;

  // next values of the timer core
  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    next_started = started;
    next_out_act = out_act;
    next_irq = 1'b0;
    next_duty = duty;
    next_duty_hold = duty_hold;
    next_pend = pend;
    next_age = age;
    // [R8] latch duty write
    if (duty_we_i) begin
      next_duty_hold = duty_wdata_i;
      next_pend = 1'b1;
      next_age = tph_pkg::AGE_RESET;
    end
    if (!count_enable_bit_i) begin
      // [R11] stop and clear
      next_cnt = tph_pkg::CNT_RESET;
      // [R2] period compared first
      next_phase = tph_pkg::TPH_CMP_PERIOD;
      next_started = 1'b0;
      // [R7] force inactive
      next_out_act = 1'b0;
      // stopped timer takes writes straight into the compare register
      if (duty_we_i) begin
        next_duty = duty_wdata_i;
        next_pend = 1'b0;
      end
    end else if (cnt_tick) begin
      // [R9] age the pending write
      if (pend && !duty_we_i && age != 2'(tph_pkg::DUTY_XFER_TICKS)) begin
        next_age = age + 1'b1;
      end
      if (!started) begin
        // [R6] mask first count clock
        next_started = 1'b1;
      end else if (cmp_period && cnt == period_compare_reg_i) begin
        // [R3] period match
        next_cnt = tph_pkg::CNT_RESET;
        next_irq = 1'b1;
        next_out_act = pwm_mode ? 1'b1 : ~out_act;
        next_phase = tph_pkg::TPH_CMP_DUTY;
      end else if (cmp_duty && cnt == duty) begin
        // [R4] duty match, counter keeps running
        next_cnt = cnt + 1'b1;
        next_out_act = 1'b0;
        next_phase = tph_pkg::TPH_CMP_PERIOD;
        // [R8] [R9] transfer only if old enough
        if (pend && !duty_we_i && age == 2'(tph_pkg::DUTY_XFER_TICKS)) begin
          next_duty = duty_hold;
          next_pend = 1'b0;
        end
      end else begin
        // [R5] count up between matches
        next_cnt = cnt + 1'b1;
      end
    end
    // [R14] [R16] pin gating and default level
    next_oe = output_drive_enable_i;
    next_pin = output_drive_enable_i ? (next_out_act ^ default_output_level_i)
                                     : default_output_level_i;
  end

  // registers of the timer core
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt <= tph_pkg::CNT_RESET;
      phase <= tph_pkg::TPH_CMP_PERIOD;
      started <= 1'b0;
      out_act <= 1'b0;
      irq <= 1'b0;
      duty <= tph_pkg::CMP_RESET;
      duty_hold <= tph_pkg::CMP_RESET;
      pend <= 1'b0;
      age <= tph_pkg::AGE_RESET;
      timer_output_pin_o <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
      started <= next_started;
      out_act <= next_out_act;
      // [R15] single cycle pulse
      irq <= next_irq;
      duty <= next_duty;
      duty_hold <= next_duty_hold;
      pend <= next_pend;
      age <= next_age;
      timer_output_pin_o <= next_pin;
      timer_output_pin_oe_o <= next_oe;
    end
  end

  assign match_interrupt_o = irq;
  assign count_o = cnt;
  assign duty_compare_reg_o = duty;

endmodule

/* verification/tph_timer_pwm_checker.sv */
// checker for the timer pwm block, watching the top module's ports only
// assumes inputs change at the clock edge and stay stable within a cycle
`timescale 1ns/1ps
module tph_timer_pwm_checker #(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic count_enable_bit_i,
  input wire logic op_mode_sel_hi_i,
  input wire logic op_mode_sel_lo_i,
  input wire logic default_output_level_i,
  input wire logic output_drive_enable_i,
  input wire logic [CNT_W-1:0] period_compare_reg_i,
  input wire logic timer_output_pin_o,
  input wire logic timer_output_pin_oe_o,
  input wire logic match_interrupt_o,
  input wire logic [CNT_W-1:0] count_o,
  input wire logic [CNT_W-1:0] duty_compare_reg_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // duty compare only exists in pwm mode
  wire logic pwm = ({op_mode_sel_hi_i, op_mode_sel_lo_i} == tph_pkg::MODE_PWM);
  // output drive enable as sampled at this edge; $past of it gives the edge before
  wire logic oe2;
  assign oe2 = output_drive_enable_i;
  AST_IRQ_ONE: assert property (match_interrupt_o |=> !match_interrupt_o)
    else $error("interrupt wider than one cycle");
  AST_PER_CLR: assert property (match_interrupt_o |-> count_o == '0 &&
    $past(count_o) == period_compare_reg_i)
    else $error("interrupt without period match and clear");
  AST_PER_ACT: assert property (match_interrupt_o && pwm && oe2 && $past(oe2) |->
    timer_output_pin_o == !default_output_level_i)
    else $error("pin not active on period match");
  AST_DUTY_OFF: assert property (pwm && count_enable_bit_i && $past(count_enable_bit_i) &&
    oe2 && $past(oe2) && $changed(timer_output_pin_o) && !match_interrupt_o |->
    $past(count_o) == $past(duty_compare_reg_o) && count_o != '0)
    else $error("pin fell without duty match or counter cleared");
  AST_MASK: assert property ($rose(count_enable_bit_i) && oe2 && $past(oe2) |->
    (timer_output_pin_o == default_output_level_i) [*2])
    else $error("pin left default right after start");
  AST_STOP: assert property (!count_enable_bit_i |=> count_o == '0 && !match_interrupt_o)
    else $error("stop did not clear counter and interrupt");
  AST_STOP_PIN: assert property (!count_enable_bit_i |=>
    timer_output_pin_o == $past(default_output_level_i))
    else $error("stop did not return pin to default");
  AST_OE_OFF: assert property (!output_drive_enable_i |=> !timer_output_pin_oe_o &&
    timer_output_pin_o == $past(default_output_level_i))
    else $error("undriven pin not at default");
  AST_OE_ON: assert property (output_drive_enable_i |=> timer_output_pin_oe_o)
    else $error("pin drive enable not followed");
  AST_XFER: assert property (count_enable_bit_i && $past(count_enable_bit_i) &&
    $changed(duty_compare_reg_o) |-> $past(count_o) == $past(duty_compare_reg_o))
    else $error("duty value moved outside a duty match");
  COV_IRQ: cover property (match_interrupt_o);
  COV_FALL: cover property (pwm && $fell(timer_output_pin_o) && count_enable_bit_i);
  COV_XFER: cover property (count_enable_bit_i && $changed(duty_compare_reg_o));
endmodule
bind tph_timer_pwm tph_timer_pwm_checker #(.CNT_W(CNT_W)) u_tph_timer_pwm_checker (.*);

/* verification/tph_load_model.sv */
// external load on the timer pin: measures high width and rise-to-rise period
// assumes one clock shared with the timer; undriven pin edges are ignored
`timescale 1ns/1ps
module tph_load_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic [15:0] high_w_o,
  output logic [15:0] period_o
);
  logic prev = 1'b0; // last pin level seen
  logic [15:0] since = 16'h0000; // clocks since last rise
  logic [15:0] hcnt = 16'h0000; // clocks high so far
  // a floating pin carries no edges worth timing
  always_ff @(posedge clk_i) begin
    prev <= pin_i;
    since <= (oe_i && pin_i && !prev) ? 16'h0001 : since + 16'h0001;
    hcnt <= pin_i ? hcnt + 16'h0001 : 16'h0000;
    if (oe_i && pin_i && !prev) period_o <= since;
    if (oe_i && !pin_i && prev) high_w_o <= hcnt;
  end
endmodule

/* verification/tph_timer_pwm_bench.sv */
// self-checking bench for the timer pwm block with a pin load model
// assumes 40 MHz clock; inputs driven by nonblocking assigns at rising edges
`timescale 1ns/1ps
module tph_timer_pwm_bench;
  logic clk = 0, nrst = 0, en = 0, lev = 0, oe = 1, we = 0, slow = 0;
  logic [2:0] cks = 3'h0;
  logic [1:0] md = tph_pkg::MODE_PWM;
  logic [7:0] per = 8'h03, wd = 8'h00, cnt, duty;
  logic pin, pin_oe, irq;
  logic [15:0] hw, pd;
  int num_errors = 0, cmp_count = 0, cyc = 0, k;
  // every entry keeps duty below period
  logic [23:0] tab [8] = '{24'h0301_00, 24'h0100_00, 24'hFF00_00, 24'hFFFE_00,
    24'h0301_10, 24'h0502_01, 24'h0201_20, 24'h0100_50};
  logic [1:0] slow_ph = 2'h0; // phase of the slow clock stand-in
  always #12.5 clk = ~clk;
  // slow clock stand-in: toggles every 4 clocks, so it rises once per 8 clocks
  always @(posedge clk) begin
    slow_ph <= slow_ph + 2'h1;
    if (slow_ph == 2'h3) slow <= ~slow;
  end
  tph_timer_pwm u_tph_timer_pwm (.ref_clk_i(clk), .nrst_i(nrst), .count_enable_bit_i(en),
    .count_clock_sel_hi_i(cks[2]), .count_clock_sel_mid_i(cks[1]), .count_clock_sel_lo_i(cks[0]),
    .op_mode_sel_hi_i(md[1]), .op_mode_sel_lo_i(md[0]), .default_output_level_i(lev),
    .output_drive_enable_i(oe), .slow_clk_tick_i(slow), .period_compare_reg_i(per),
    .duty_wdata_i(wd), .duty_we_i(we), .timer_output_pin_o(pin), .timer_output_pin_oe_o(pin_oe),
    .match_interrupt_o(irq), .count_o(cnt), .duty_compare_reg_o(duty));
  tph_load_model u_tph_load_model (.clk_i(clk), .pin_i(pin), .oe_i(pin_oe), .high_w_o(hw),
    .period_o(pd));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait on a pin level or the interrupt, sampled mid-cycle
  task automatic wait_for(bit use_irq);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(negedge clk);
      if (use_irq ? irq === 1'b1 : pin === 1'b0) break;
    end
    if (i == 5000) chk("wait", 16'h0001, 16'h0000);
  endtask
  task automatic write_duty(logic [7:0] v);
    @(posedge clk);
    wd <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic stop_chk();
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(negedge clk);
    chk("count", 16'h0000, {8'h00, cnt});
    chk("pin", {15'h0000, lev}, {15'h0000, pin});
  endtask
  // stopped setup, duty rewritten before every start, then three periods
  task automatic run(logic [7:0] n, logic [7:0] m, logic [2:0] c, logic l);
    int d;
    // count clock length in ref clocks; the slow input rises every 8 clocks, divided by 128
    d = (c == tph_pkg::CKS_DIV4) ? 4 : (c == tph_pkg::CKS_DIV16) ? 16 :
      (c == tph_pkg::CKS_SLOW) ? 8 * 128 : 1;
    @(posedge clk);
    // period and mode bits set only while stopped
    per <= n;
    cks <= c;
    lev <= l;
    write_duty(m);
    @(posedge clk);
    en <= 1'b1;
    repeat (3) wait_for(1);
    chk("period", 16'(d * (n + 1)), pd);
    chk("high", 16'(d * (l ? n - m : m + 1)), hw);
    chk("duty", {8'h00, m}, {8'h00, duty});
  endtask
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("reset", 16'h0000, {cnt, duty});
    for (k = 0; k < 8; k++) begin
      run(tab[k][23:16], tab[k][15:8], tab[k][6:4], tab[k][0]);
      stop_chk();
    end
    // unused clock code never counts
    @(posedge clk);
    cks <= 3'h6;
    en <= 1'b1;
    repeat (40) @(negedge clk);
    chk("no count", 16'h0000, {8'h00, cnt});
    stop_chk();
    run(8'hA5, 8'h01, 3'h0, 1'b0);
    wait_for(1);
    write_duty(8'h03);
    wait_for(0);
    chk("late duty", 16'h0001, {8'h00, duty});
    wait_for(1);
    wait_for(0);
    chk("new duty", 16'h0003, {8'h00, duty});
    repeat (2) wait_for(1);
    chk("new high", 16'h0004, hw);
    @(posedge clk);
    oe <= 1'b0;
    repeat (300) @(negedge clk);
    chk("undriven", 16'h0000, {15'h0000, pin_oe});
    @(posedge clk);
    oe <= 1'b1;
    stop_chk();
    give_verdict();
  end
endmodule
